// [async_serial_txrx_core.sv]
// Asynchronous serial transmit/receive core with fractional divisor
`timescale 1ns/1ns
module async_serial_txrx_core #(
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rd_data_o,
    input wire logic serial_rx_line_i,
    output logic serial_tx_line_o
);
    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} frame_st_t;

    localparam logic [AW:0] QFULL = (AW + 1)'(DEPTH);
    localparam logic [AW:0] QONE = (AW + 1)'(1);

    // Parity of the active data bits; stick parity overrides
    function automatic logic par_bit(input logic [7:0] d, input logic [1:0] wl,
                                     input logic ev, input logic st);
        logic [7:0] m;
        m = 8'hff >> ~wl;
        par_bit = st ? ~ev : (ev ? ^(d & m) : ~^(d & m));
    endfunction : par_bit

    logic [15:0] ctl_r;
    logic [15:0] ibrd_r;
    logic [5:0] fbrd_r;
    logic [7:0] lcr_r;
    logic [29:0] cfg_r;
    logic [3:0] rsr_r;
    logic [3:0] rsr_nxt;
    logic [15:0] rd_data_r;
    logic tx_r;

    // Address decode
    wire sel_data = addr_i == serial_pkg::DATA_OFS;
    wire sel_rsr = addr_i == serial_pkg::RSR_OFS;
    wire sel_flag = addr_i == serial_pkg::FLAG_OFS;
    wire sel_ibrd = addr_i == serial_pkg::IBRD_OFS;
    wire sel_fbrd = addr_i == serial_pkg::FBRD_OFS;
    wire sel_lcr = addr_i == serial_pkg::LCR_OFS;
    wire sel_ctl = addr_i == serial_pkg::CTL_OFS;
    wire lcr_wr = wr_i & sel_lcr;

    // Divisor and line settings come only from the 30-bit shadow; enables come from ctl_r
    wire [15:0] divisor_int_part = cfg_r[29:14];
    wire [5:0] divisor_frac_part = cfg_r[13:8];
    wire brk = cfg_r[serial_pkg::LCR_BRK];
    wire pen = cfg_r[serial_pkg::LCR_PEN];
    wire eps = cfg_r[serial_pkg::LCR_EPS];
    wire stp2 = cfg_r[serial_pkg::LCR_STP2];
    wire queue_enable_bit = cfg_r[serial_pkg::LCR_FEN];
    wire [1:0] wlen = cfg_r[serial_pkg::LCR_WLEN +: 2];
    wire sps = cfg_r[serial_pkg::LCR_SPS];
    wire port_global_enable = ctl_r[serial_pkg::CTL_EN];
    wire tx_enable_bit = ctl_r[serial_pkg::CTL_TXE];
    wire rx_enable_bit = ctl_r[serial_pkg::CTL_RXE];
    wire [2:0] last_bit = {1'b0, wlen} + 3'h4;
    wire [AW:0] q_lim = queue_enable_bit ? QFULL : QONE;

    // Fractional divisor: period is int or int+1 cycles by carry
    logic [16:0] bd_cnt_r;
    logic [5:0] bd_acc_r;
    logic oversample_tick;
    wire [6:0] acc_sum = {1'b0, bd_acc_r} + {1'b0, divisor_frac_part};
    wire bd_wrap = (bd_cnt_r == 17'h0) && (divisor_int_part != 16'h0);
    wire [16:0] bd_reload = {1'b0, divisor_int_part} - 17'h1 + {16'h0, acc_sum[6]};

    // Oversample tick generator, sixteen per bit
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            bd_cnt_r <= 17'h0;
            bd_acc_r <= 6'h0;
            oversample_tick <= 1'b0;
        end else begin
            oversample_tick <= bd_wrap;
            if (bd_wrap) begin
                bd_cnt_r <= bd_reload;
                bd_acc_r <= acc_sum[5:0];
            end else if (bd_cnt_r != 17'h0) begin
                bd_cnt_r <= bd_cnt_r - 17'h1;
            end
        end
    end

    // Transmit queue
    logic [7:0] txq [DEPTH];
    logic [AW-1:0] txw_r;
    logic [AW-1:0] txr_r;
    logic [AW:0] txc_r;
    wire tx_empty = txc_r == '0;
    wire tx_full = txc_r >= q_lim;
    wire tx_push = wr_i & sel_data & ~tx_full;
    logic tx_pop;

    // Receive queue, four error bits above each character
    logic [11:0] rxq [DEPTH];
    logic [AW-1:0] rxw_r;
    logic [AW-1:0] rxr_r;
    logic [AW:0] rxc_r;
    wire rx_empty = rxc_r == '0;
    wire rx_full = rxc_r >= q_lim;
    wire rx_pop = rd_i & sel_data & ~rx_empty;
    logic rx_done;
    logic [11:0] rx_entry;
    wire rx_push = rx_done & ~rx_full;
    wire rx_ovr = rx_done & rx_full;

    // Queue storage; no reset needed on data
    always_ff @(posedge ref_clk_i) begin
        if (tx_push) begin
            txq[txw_r] <= wr_data_i[7:0];
        end
        if (rx_push) begin
            rxq[rxw_r] <= rx_entry;
        end
    end

    // Queue pointers and counts
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            txw_r <= '0;
            txr_r <= '0;
            txc_r <= '0;
            rxw_r <= '0;
            rxr_r <= '0;
            rxc_r <= '0;
        end else begin
            txw_r <= txw_r + AW'(tx_push);
            txr_r <= txr_r + AW'(tx_pop);
            txc_r <= txc_r + (AW + 1)'(tx_push) - (AW + 1)'(tx_pop);
            rxw_r <= rxw_r + AW'(rx_push);
            rxr_r <= rxr_r + AW'(rx_pop);
            rxc_r <= rxc_r + (AW + 1)'(rx_push) - (AW + 1)'(rx_pop);
        end
    end

    // Transmitter
    frame_st_t tx_st_r;
    logic [3:0] tx_sub_r;
    logic [2:0] tx_bit_r;
    logic [7:0] tx_sh_r;
    logic tx_par_r;
    logic tx_line_nxt;
    // Frames start only from idle; enable is not looked at mid-frame
    wire tx_go = (tx_st_r == ST_IDLE) & port_global_enable & tx_enable_bit
               & ~tx_empty & oversample_tick;
    wire tx_end = oversample_tick & (tx_sub_r == serial_pkg::OVS_LAST);
    wire tx_busy = ~tx_empty | (tx_st_r != ST_IDLE);
    assign tx_pop = tx_go;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_st_r <= ST_IDLE;
            tx_sub_r <= 4'h0;
            tx_bit_r <= 3'h0;
            tx_sh_r <= 8'h0;
            tx_par_r <= 1'b0;
        end else begin
            if (tx_st_r != ST_IDLE && oversample_tick) begin
                tx_sub_r <= tx_sub_r + 4'h1;
            end
            case (tx_st_r)
                ST_IDLE: begin
                    if (tx_go) begin
                        tx_st_r <= ST_START;
                        tx_sub_r <= 4'h0;
                        tx_sh_r <= txq[txr_r];
                        tx_par_r <= par_bit(txq[txr_r], wlen, eps, sps);
                    end
                end
                ST_START: begin
                    if (tx_end) begin
                        tx_st_r <= ST_DATA;
                        tx_bit_r <= 3'h0;
                    end
                end
                ST_DATA: begin
                    if (tx_end) begin
                        tx_sh_r <= {1'b0, tx_sh_r[7:1]};
                        tx_bit_r <= tx_bit_r + 3'h1;
                        if (tx_bit_r == last_bit) begin
                            tx_st_r <= pen ? ST_PAR : ST_STOP;
                            tx_bit_r <= 3'h0;
                        end
                    end
                end
                ST_PAR: begin
                    if (tx_end) begin
                        tx_st_r <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (tx_end) begin
                        if (stp2 && tx_bit_r == 3'h0) begin
                            tx_bit_r <= 3'h1;
                        end else begin
                            tx_st_r <= ST_IDLE;
                        end
                    end
                end
                default: tx_st_r <= ST_IDLE;
            endcase
        end
    end

    // Line level per state; break forces the line low
    always_comb begin
        case (tx_st_r)
            ST_START: tx_line_nxt = 1'b0;
            ST_DATA: tx_line_nxt = tx_sh_r[0];
            ST_PAR: tx_line_nxt = tx_par_r;
            default: tx_line_nxt = 1'b1;
        endcase
        if (brk) begin
            tx_line_nxt = 1'b0;
        end
    end

    // Receiver
    frame_st_t rx_st_r;
    logic [3:0] rx_sub_r;
    logic [2:0] rx_bit_r;
    logic [7:0] rx_sh_r;
    logic rx_pbit_r;
    logic rx_pe_r;
    logic rx_prev_r;
    logic ovr_pend_r;
    wire rx_i = serial_rx_line_i;
    wire [7:0] rx_data = rx_sh_r >> ~wlen;
    wire rx_samp = oversample_tick & (rx_sub_r == serial_pkg::OVS_LAST);
    wire rx_fall = rx_prev_r & ~rx_i & port_global_enable & rx_enable_bit;
    wire rx_stop = (rx_st_r == ST_STOP) & rx_samp;
    // Break: data, parity and stop all low
    wire rx_brk = ~rx_i & (rx_data == 8'h0) & (~pen | ~rx_pbit_r);
    assign rx_done = rx_stop;
    assign rx_entry = {ovr_pend_r, rx_brk, rx_pe_r, ~rx_i, rx_data};

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_st_r <= ST_IDLE;
            rx_sub_r <= 4'h0;
            rx_bit_r <= 3'h0;
            rx_sh_r <= 8'h0;
            rx_pbit_r <= 1'b0;
            rx_pe_r <= 1'b0;
            rx_prev_r <= 1'b1;
            ovr_pend_r <= 1'b0;
        end else begin
            rx_prev_r <= rx_i;
            if (rx_ovr) begin
                ovr_pend_r <= 1'b1;
            end else if (rx_push) begin
                ovr_pend_r <= 1'b0;
            end
            if (rx_st_r != ST_IDLE && oversample_tick) begin
                rx_sub_r <= rx_sub_r + 4'h1;
            end
            case (rx_st_r)
                ST_IDLE: begin
                    if (rx_fall) begin
                        rx_st_r <= ST_START;
                        rx_sub_r <= 4'h0;
                    end
                end
                ST_START: begin
                    if (oversample_tick && rx_sub_r == serial_pkg::START_CHECK) begin
                        rx_st_r <= rx_i ? ST_IDLE : ST_DATA;
                        rx_sub_r <= 4'h0;
                        rx_bit_r <= 3'h0;
                        rx_pe_r <= 1'b0;
                        rx_pbit_r <= 1'b0;
                    end
                end
                ST_DATA: begin
                    if (rx_samp) begin
                        rx_sh_r <= {rx_i, rx_sh_r[7:1]};
                        rx_bit_r <= rx_bit_r + 3'h1;
                        if (rx_bit_r == last_bit) begin
                            rx_st_r <= pen ? ST_PAR : ST_STOP;
                        end
                    end
                end
                ST_PAR: begin
                    if (rx_samp) begin
                        rx_pbit_r <= rx_i;
                        rx_pe_r <= rx_i != par_bit(rx_data, wlen, eps, sps);
                        rx_st_r <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (rx_samp) begin
                        rx_st_r <= ST_IDLE;
                    end
                end
                default: rx_st_r <= ST_IDLE;
            endcase
        end
    end

    // Receive status: set by a pop or overrun wins over a clearing write
    always_comb begin
        rsr_nxt = (wr_i & sel_rsr) ? 4'h0 : rsr_r;
        if (rx_pop) begin
            rsr_nxt[2:0] = rxq[rxr_r][10:8];
        end
        if (rx_ovr) begin
            rsr_nxt[3] = 1'b1;
        end
    end

    // Read data selection
    wire [15:0] flag_w = {8'h0, tx_empty, rx_full, tx_full, rx_empty, tx_busy, 3'h0};
    wire [15:0] rd_mux = sel_data ? (rx_empty ? 16'h0 : {4'h0, rxq[rxr_r]})
                       : sel_rsr ? {12'h0, rsr_r}
                       : sel_flag ? flag_w
                       : sel_ibrd ? ibrd_r
                       : sel_fbrd ? {10'h0, fbrd_r}
                       : sel_lcr ? {8'h0, lcr_r}
                       : sel_ctl ? ctl_r
                       : 16'h0;

    // Register file and output flops
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctl_r <= serial_pkg::CTL_RESET;
            ibrd_r <= 16'h0;
            fbrd_r <= 6'h0;
            lcr_r <= 8'h0;
            cfg_r <= 30'h0;
            rsr_r <= 4'h0;
            rd_data_r <= 16'h0;
            tx_r <= 1'b1;
        end else begin
            rsr_r <= rsr_nxt;
            tx_r <= tx_line_nxt;
            rd_data_r <= rd_i ? rd_mux : rd_data_r;
            if (wr_i && sel_ctl) begin
                ctl_r <= wr_data_i;
            end
            if (wr_i && sel_ibrd) begin
                ibrd_r <= wr_data_i;
            end
            if (wr_i && sel_fbrd) begin
                fbrd_r <= wr_data_i[5:0];
            end
            if (lcr_wr) begin
                lcr_r <= wr_data_i[7:0];
                cfg_r <= {ibrd_r, fbrd_r, wr_data_i[7:0]};
            end
        end
    end

    assign rd_data_o = rd_data_r;
    assign serial_tx_line_o = tx_r;

    AST_CTL_RESET: assert property (@(posedge ref_clk_i)
        $fell(reset_i) |-> (ctl_r[9:8] == 2'b11))
        else $error("enables not set after reset");
    AST_CFG_LOAD: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        lcr_wr |=> (cfg_r == {$past(ibrd_r), $past(fbrd_r), $past(wr_data_i[7:0])}))
        else $error("shadow not loaded on line control write");
    AST_CFG_HOLD: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !lcr_wr |=> $stable(cfg_r))
        else $error("shadow changed without line control write");
    AST_TX_IDLE_HIGH: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (tx_st_r == ST_IDLE && !brk) |=> serial_tx_line_o)
        else $error("tx line low while idle");
    AST_TX_START_LOW: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (tx_st_r == ST_START && !brk) |=> !serial_tx_line_o)
        else $error("start bit not low");
    AST_TX_FINISH: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (tx_st_r == ST_DATA) |=> (tx_st_r != ST_IDLE))
        else $error("frame cut short");
    AST_BUSY_FALL: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        $fell(tx_busy) |-> (tx_empty && $past(tx_st_r) == ST_STOP))
        else $error("busy dropped early");
    AST_START_REJECT: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (rx_st_r == ST_START && oversample_tick && rx_sub_r == 4'h7 && rx_i)
        |=> (rx_st_r == ST_IDLE))
        else $error("false start accepted");
    AST_FRAMING: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (rx_stop && !rx_i && !rx_full) |-> (rx_push && rx_entry[serial_pkg::ERR_FE]))
        else $error("framing error not flagged");
    AST_QUEUE_DEPTH1: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !queue_enable_bit |-> ##1 (rxc_r <= QONE || $past(queue_enable_bit)))
        else $error("queue deeper than one while disabled");
    AST_RD_WIDTH: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (rd_i && sel_data) |=> (rd_data_o[15:12] == 4'h0))
        else $error("data read wider than 12 bits");
endmodule : async_serial_txrx_core

// [async_serial_txrx_core_test.sv]
// Self-checking testbench for the serial transmit/receive core
`timescale 1ns/1ns
module async_serial_txrx_core_test;
    logic ref_clk, reset, wr, rd, rx_line, tx_line, par, stp, seen;
    logic [7:0] addr, got;
    logic [15:0] wr_data, rd_data, v;
    int n_errors = 0;
    int num_checks = 0;

    async_serial_txrx_core DUT (.ref_clk_i(ref_clk), .reset_i(reset), .addr_i(addr),
        .wr_data_i(wr_data), .wr_i(wr), .rd_i(rd), .rd_data_o(rd_data),
        .serial_rx_line_i(rx_line), .serial_tx_line_o(tx_line));
    serial_remote_model far (.ref_clk_i(ref_clk), .tx_line_i(tx_line), .rx_line_o(rx_line));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop();
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [15:0] seen_v, input logic [15:0] exp_v);
        num_checks++;
        if (seen_v !== exp_v) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp_v, seen_v);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data is registered on the strobe and held until the next read
    task automatic rd_reg(input logic [7:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 v = rd_data;
    endtask : rd_reg

    task automatic recv_chk(input logic [7:0] exp, input int nbits, input logic pen);
        far.recv(nbits, pen, got, par, stp, seen);
        check("tx frame found", {15'h0000, seen}, 16'h0001);
        check("tx data", {8'h00, got}, exp);
        check("tx stop", {15'h0000, stp}, 16'h0001);
    endtask : recv_chk

    // Disabling around each line control write keeps the line settings coherent
    task automatic set_line(input logic [15:0] lcr);
        wr_reg(serial_pkg::CTL_OFS, 16'h0300);
        wr_reg(serial_pkg::LCR_OFS, lcr);
        wr_reg(serial_pkg::CTL_OFS, 16'h0301);
    endtask : set_line

    // Watchdog: the run needs a few thousand cycles, 20000 is ample
    initial begin
        #400000;
        n_errors++;
        report_and_stop();
    end

    initial begin
        reset = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wr_data = 16'h0000;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        #1 check("tx idle", {15'h0000, tx_line}, 16'h0001);
        rd_reg(serial_pkg::CTL_OFS);
        check("ctl reset", v, 16'h0300);
        rd_reg(8'h40);
        check("unmapped read", v, 16'h0000);
        // Divisor 1.0 gives one tick per clock, 16 clocks per bit
        wr_reg(serial_pkg::IBRD_OFS, 16'h0001);
        wr_reg(serial_pkg::FBRD_OFS, 16'h0000);
        set_line(16'h0060);
        fork
            recv_chk(8'ha5, 8, 1'b0);
            begin
                wr_reg(serial_pkg::DATA_OFS, 16'h00a5);
                rd_reg(serial_pkg::FLAG_OFS);
                check("busy on write", v & 16'h0008, 16'h0008);
            end
        join
        repeat (24) @(posedge ref_clk);
        rd_reg(serial_pkg::FLAG_OFS);
        check("busy after stop", v & 16'h0008, 16'h0000);
        // Queue disabled: second character overruns the single holder
        far.send(8'h3c, 1'b0, 1'b0, 1'b1);
        far.send(8'h5a, 1'b0, 1'b0, 1'b1);
        rd_reg(serial_pkg::DATA_OFS);
        check("rx first", v, 16'h003c);
        rd_reg(serial_pkg::DATA_OFS);
        check("rx holder empty", v, 16'h0000);
        rd_reg(serial_pkg::RSR_OFS);
        check("overrun sticky", v & 16'h0008, 16'h0008);
        far.glitch(4);
        repeat (40) @(posedge ref_clk);
        rd_reg(serial_pkg::FLAG_OFS);
        check("glitch ignored", v & 16'h0010, 16'h0010);
        // Queue on, 8 bits, even parity; three entries stored in order
        set_line(16'h0076);
        far.send(8'h81, 1'b1, 1'b0, 1'b0);
        far.send(8'h42, 1'b1, 1'b1, 1'b1);
        far.send(8'h42, 1'b1, 1'b0, 1'b1);
        rd_reg(serial_pkg::DATA_OFS);
        check("rx framing", v, 16'h0981);
        rd_reg(serial_pkg::DATA_OFS);
        check("rx parity", v, 16'h0242);
        rd_reg(serial_pkg::DATA_OFS);
        check("rx clean", v, 16'h0042);
        // All-low character with low stop is a break, also a framing error
        far.send(8'h00, 1'b1, 1'b0, 1'b0);
        rd_reg(serial_pkg::DATA_OFS);
        check("rx break", v, 16'h0500);
        fork
            recv_chk(8'h07, 8, 1'b1);
            wr_reg(serial_pkg::DATA_OFS, 16'h0007);
        join
        check("tx parity", {15'h0000, par}, 16'h0001);
        // Five-bit characters written back to back
        set_line(16'h0010);
        fork
            begin
                recv_chk(8'h1f, 5, 1'b0);
                recv_chk(8'h0a, 5, 1'b0);
            end
            begin
                wr_reg(serial_pkg::DATA_OFS, 16'h00ff);
                wr_reg(serial_pkg::DATA_OFS, 16'h000a);
            end
        join
        // New divisor without a line write must not change the bit time
        set_line(16'h0060);
        wr_reg(serial_pkg::IBRD_OFS, 16'h0003);
        fork
            recv_chk(8'h96, 8, 1'b0);
            begin
                wr_reg(serial_pkg::DATA_OFS, 16'h0096);
                repeat (40) @(posedge ref_clk);
                wr_reg(serial_pkg::CTL_OFS, 16'h0300);
                rd_reg(serial_pkg::FLAG_OFS);
                check("busy when disabled", v & 16'h0008, 16'h0008);
            end
        join
        repeat (24) @(posedge ref_clk);
        rd_reg(serial_pkg::FLAG_OFS);
        check("busy done", v & 16'h0008, 16'h0000);
        check("tx idle end", {15'h0000, tx_line}, 16'h0001);
        report_and_stop();
    end
endmodule : async_serial_txrx_core_test

// [serial_pkg.sv]
// Constants for the asynchronous serial transmit/receive core
package serial_pkg;
    // Register offsets
    localparam logic [7:0] DATA_OFS = 8'h00;
    localparam logic [7:0] RSR_OFS = 8'h04;
    localparam logic [7:0] FLAG_OFS = 8'h18;
    localparam logic [7:0] IBRD_OFS = 8'h24;
    localparam logic [7:0] FBRD_OFS = 8'h28;
    localparam logic [7:0] LCR_OFS = 8'h2c;
    localparam logic [7:0] CTL_OFS = 8'h30;
    // Control register
    localparam logic [15:0] CTL_RESET = 16'h0300;
    localparam int CTL_EN = 0;
    localparam int CTL_TXE = 8;
    localparam int CTL_RXE = 9;
    // Line control fields
    localparam int LCR_BRK = 0;
    localparam int LCR_PEN = 1;
    localparam int LCR_EPS = 2;
    localparam int LCR_STP2 = 3;
    localparam int LCR_FEN = 4;
    localparam int LCR_WLEN = 5;
    localparam int LCR_SPS = 7;
    // Flag register bits
    localparam int FLAG_BUSY = 3;
    // Error bits of a receive entry, above the 8 data bits
    localparam int ERR_FE = 8;
    localparam int ERR_PE = 9;
    localparam int ERR_BE = 10;
    localparam int ERR_OE = 11;
    // Oversampling: last tick of a bit and start-check tick
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] START_CHECK = 4'h7;
endpackage : serial_pkg

// [serial_remote_model.sv]
// Remote serial transceiver model facing the core's tx and rx lines
`timescale 1ns/1ns
module serial_remote_model #(
    parameter int BIT_CLKS = 16
) (
    input wire logic ref_clk_i,
    input wire logic tx_line_i,
    output logic rx_line_o
);
    // Line rests high between frames, like a pulled-up idle line
    initial begin
        rx_line_o = 1'b1;
    end

    task automatic wait_clks(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : wait_clks

    // Start, data LSB first, optional even parity, one stop bit
    task automatic send(input logic [7:0] d, input logic pen, input logic pflip,
                        input logic stop_v);
        @(posedge ref_clk_i);
        rx_line_o <= 1'b0;
        wait_clks(BIT_CLKS);
        for (int i = 0; i < 8; i++) begin
            rx_line_o <= d[i];
            wait_clks(BIT_CLKS);
        end
        if (pen) begin
            rx_line_o <= (^d) ^ pflip; // Flip only when a bad parity is wanted
            wait_clks(BIT_CLKS);
        end
        rx_line_o <= stop_v;
        wait_clks(BIT_CLKS);
        rx_line_o <= 1'b1;
        wait_clks(2 * BIT_CLKS);
    endtask : send

    // Short low pulse that must not pass for a start bit
    task automatic glitch(input int n);
        @(posedge ref_clk_i);
        rx_line_o <= 1'b0;
        wait_clks(n);
        rx_line_o <= 1'b1;
    endtask : glitch

    // Samples each bit in its middle; gives up after a bounded wait
    task automatic recv(input int nbits, input logic pen, output logic [7:0] d,
                        output logic p, output logic s, output logic found);
        int t;
        d = 8'h00;
        p = 1'b0;
        s = 1'b0;
        found = 1'b0;
        t = 0;
        while (tx_line_i !== 1'b0 && t < 400) begin
            @(posedge ref_clk_i);
            t++;
        end
        if (tx_line_i === 1'b0) begin
            found = 1'b1;
            wait_clks(BIT_CLKS / 2);
            for (int i = 0; i < nbits; i++) begin
                wait_clks(BIT_CLKS);
                d[i] = tx_line_i;
            end
            if (pen) begin
                wait_clks(BIT_CLKS);
                p = tx_line_i;
            end
            wait_clks(BIT_CLKS);
            s = tx_line_i;
        end
    endtask : recv
endmodule : serial_remote_model
